// ===== pkg/ddt_consts.svh
// constants for the deskew loopback training block
`ifndef DDT_CONSTS_SVH
`define DDT_CONSTS_SVH
// looped input count and bus widths
`define DDT_NLB       12
`define DDT_DQW       36
`define DDT_INVW      4
// output latency in main-clock cycles
`define DDT_LAT       5
// command-free guard in main-clock cycles after exit
`define DDT_GUARD     16
`define DDT_GUARD_W   5
// auto-mask pattern codes
`define DDT_DMP_B0    2'h0
`define DDT_DMP_B1    2'h2
`define DDT_DMP_B2    2'h1
`define DDT_DMP_B3    2'h3
// reset values
`define DDT_PLL_RST   1'h0
`define DDT_ADM_RST   1'h0
`define DDT_DMP_RST   2'h0
`define DDT_INVERSION_FLAG_LINES_RST  1'h0
`endif

// ===== pkg/ddt_pkg.sv
// types for the deskew loopback training block
package ddt_pkg;
  // training mode state, gray along normal -> loop -> exit guard
  typedef enum logic [1:0] {
    DDT_NORM = 2'h0,
    DDT_LOOP = 2'h1,
    DDT_EXIT = 2'h3
  } ddt_state_type;
endpackage

// ===== design/ddt_loopback.sv
// device-side loopback deskew training and config bits
`timescale 1ns/1ps
`include "ddt_consts.svh"

// Contract
// - select low loops control pins to outputs
// - all looped pins sampled by main clock
// - wide part output positions per ball
// - clock pairs loop the receiver output (narrow part places no output for ball 3, write_data_clocks[1])
// - sample on both main clock edges
// - rising sample driven unchanged on rise
// - falling sample driven inverted on fall
// - no data inversion during loopback
// - output exactly five main cycles later
// - unmapped outputs carry no meaning
// - no commands decoded, self refresh runs
// - phase-locked loop bypassed in loopback
// - loop enable setting kept across loopback
// - training leaves stored contents alone
// - no refresh accepted during the exit guard
// - pattern field selects the one written beat
// - loop control resets to off
module ddt_loopback #(
  parameter bit WIDE = 1'b1             // 1: wide part, 0: narrow part
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // pins from the controller, named by mirror-off function
  input  wire logic                    main_clk_pin,
  input  wire logic                    loopback_select_n,
  input  wire logic                    mirror_select,
  input  wire logic [1:0]              write_data_clocks,
  input  wire logic                    cs_n,
  input  wire logic                    we_n,
  input  wire logic                    ref_n,
  input  wire logic [6:0]              address_inputs,
  // mode register write from the core decoder
  input  wire logic                    cfg_wr,
  input  wire logic                    cfg_pll,
  input  wire logic                    cfg_adm,
  input  wire logic [1:0]              cfg_dmp,
  input  wire logic                    cfg_inversion_flag_lines,
  // read data from the array
  input  wire logic [`DDT_DQW-1:0]     rd_data,
  input  wire logic [`DDT_INVW-1:0]    rd_inv,
  input  wire logic                    rd_valid,
  // data pins
  output logic      [`DDT_DQW-1:0]     dq_out,
  output logic                         dq_oe_n,
  output logic      [`DDT_INVW-1:0]    inversion_flag_lines,
  output logic                         read_data_clocks,
  // decoded commands
  output logic                         cmd_valid,
  output logic                         cmd_we,
  output logic                         cmd_ref,
  // core control
  output logic                         self_refresh,
  output logic                         pll_bypass,
  output logic                         pll_run,
  output logic                         inv_enable,
  output logic      [3:0]              beat_mask
);

  // places looped samples on output positions by ball
  function automatic logic [`DDT_DQW-1:0] place(input logic [`DDT_NLB-1:0] v);
    logic [`DDT_DQW-1:0] r;
    r = '0;
    r[0] = v[0];
    r[1] = v[1];
    r[3] = v[2];
    if (WIDE)
    begin
      r[14] = v[3];
      r[18] = v[4];
      r[19] = v[5];
      r[20] = v[6];
      r[21] = v[7];
      r[22] = v[8];
      r[25] = v[9];
      r[24] = v[10];
      r[26] = v[11];
    end
    else
    begin
      r[9]  = v[4];
      r[10] = v[5];
      r[11] = v[6];
      r[12] = v[7];
      r[13] = v[8];
      r[16] = v[9];
      r[15] = v[10];
      r[17] = v[11];
    end
    return r;
  endfunction

  // one-hot write beat from auto-mask pattern
  function automatic logic [3:0] beat_sel(input logic [1:0] p);
    case (p)
      `DDT_DMP_B0: beat_sel = 4'h1;
      `DDT_DMP_B1: beat_sel = 4'h2;
      `DDT_DMP_B2: beat_sel = 4'h4;
      default:     beat_sel = 4'h8;
    endcase
  endfunction

  // pin vector: loopback select, main clock, looped balls
  localparam int SW = `DDT_NLB + 2;
  logic [SW-1:0]          pin_raw;                // raw pins
  logic [SW-1:0]          s1_q, s1_d;             // first sync stage
  logic [SW-1:0]          s2_q, s2_d;             // second sync stage
  logic                   ck_dly_q, ck_dly_d;     // main clock one cycle late
  logic                   ck_rise, ck_fall;       // main clock edges
  logic                   lbk_n_s;                // synced select
  logic [`DDT_NLB-1:0]    loop_s;                 // synced looped balls
  logic                   mir1_q, mir1_d;         // mirror strap, first stage
  logic                   mir2_q, mir2_d;         // mirror strap, second stage

  // loop vector by ball, receiver outputs for clock pairs
  assign pin_raw = {loopback_select_n, main_clk_pin,
                    address_inputs[1], address_inputs[0], ref_n, address_inputs[2],
                    we_n, cs_n, address_inputs[3], address_inputs[4],
                    write_data_clocks[1], address_inputs[5], write_data_clocks[0],
                    address_inputs[6]};

  // synchronisers for every pin input
  always_comb
  begin
    s1_d     = pin_raw;
    s2_d     = s1_q;
    ck_dly_d = s2_q[SW-2];
    mir1_d   = mirror_select;
    mir2_d   = mir1_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1_q     <= '1;
      s2_q     <= '1;
      // matches the preset stage so no false rise follows reset
      ck_dly_q <= 1'b1;
      mir1_q   <= 1'b0;
      mir2_q   <= 1'b0;
    end
    else
    begin
      s1_q     <= s1_d;
      s2_q     <= s2_d;
      ck_dly_q <= ck_dly_d;
      mir1_q   <= mir1_d;
      mir2_q   <= mir2_d;
    end
  end

  // edges of the main clock, all looped pins use it
  assign ck_rise = s2_q[SW-2] & ~ck_dly_q;
  assign ck_fall = ~s2_q[SW-2] & ck_dly_q;
  assign lbk_n_s = s2_q[SW-1];
  assign loop_s  = s2_q[`DDT_NLB-1:0];

  // training state and exit guard counter
  ddt_pkg::ddt_state_type st_q, st_d;     // training state
  logic [`DDT_GUARD_W-1:0] gcnt_q, gcnt_d; // exit guard count

  always_comb
  begin
    st_d   = st_q;
    gcnt_d = gcnt_q;
    case (st_q)
      ddt_pkg::DDT_NORM:
      begin
        // select low enters loopback
        if (!lbk_n_s)
          st_d = ddt_pkg::DDT_LOOP;
      end
      ddt_pkg::DDT_LOOP:
      begin
        // select high starts the quiet guard
        if (lbk_n_s)
        begin
          st_d   = ddt_pkg::DDT_EXIT;
          gcnt_d = '0;
        end
      end
      ddt_pkg::DDT_EXIT:
      begin
        // decode stays off for the guard cycles
        if (!lbk_n_s)
          st_d = ddt_pkg::DDT_LOOP;
        else if (ck_rise)
        begin
          if (gcnt_q == `DDT_GUARD_W'(`DDT_GUARD - 1))
            st_d = ddt_pkg::DDT_NORM;
          else
            gcnt_d = gcnt_q + 1'b1;
        end
      end
      default:
        st_d = ddt_pkg::DDT_NORM;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q   <= ddt_pkg::DDT_NORM;
      gcnt_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      gcnt_q <= gcnt_d;
    end
  end

  // sample pipelines, one entry per main-clock cycle
  logic [`DDT_NLB-1:0] rise_q [`DDT_LAT];
  logic [`DDT_NLB-1:0] rise_d [`DDT_LAT];
  logic [`DDT_NLB-1:0] fall_q [`DDT_LAT];
  logic [`DDT_NLB-1:0] fall_d [`DDT_LAT];

  always_comb
  begin
    rise_d = rise_q;
    fall_d = fall_q;
    // both edges captured, shifted per edge
    if (ck_rise)
    begin
      rise_d[0] = loop_s;
      for (int i = 1; i < `DDT_LAT; i++)
        rise_d[i] = rise_q[i-1];
    end
    if (ck_fall)
    begin
      fall_d[0] = loop_s;
      for (int i = 1; i < `DDT_LAT; i++)
        fall_d[i] = fall_q[i-1];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `DDT_LAT; i++)
      begin
        rise_q[i] <= '0;
        fall_q[i] <= '0;
      end
    end
    else
    begin
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // mode bits, written only by decoded mode register sets
  logic       pll_en_q, pll_en_d;   // loop enable setting
  logic       adm_q, adm_d;         // auto mask enable
  logic [1:0] dmp_q, dmp_d;         // auto mask pattern
  logic       inversion_flag_lines_q, inversion_flag_lines_d;       // data inversion setting

  always_comb
  begin
    pll_en_d = pll_en_q;
    adm_d    = adm_q;
    dmp_d    = dmp_q;
    inversion_flag_lines_d   = inversion_flag_lines_q;
    // loopback never touches these settings
    if (cfg_wr && st_q == ddt_pkg::DDT_NORM)
    begin
      pll_en_d = cfg_pll;
      adm_d    = cfg_adm;
      dmp_d    = cfg_dmp;
      inversion_flag_lines_d   = cfg_inversion_flag_lines;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pll_en_q <= `DDT_PLL_RST;
      adm_q    <= `DDT_ADM_RST;
      dmp_q    <= `DDT_DMP_RST;
      inversion_flag_lines_q   <= `DDT_INVERSION_FLAG_LINES_RST;
    end
    else
    begin
      pll_en_q <= pll_en_d;
      adm_q    <= adm_d;
      dmp_q    <= dmp_d;
      inversion_flag_lines_q   <= inversion_flag_lines_d;
    end
  end

  // pin outputs and command decode
  logic [`DDT_DQW-1:0]  dq_q, dq_d;
  logic                 oe_n_q, oe_n_d;
  logic [`DDT_INVW-1:0] inv_q, inv_d;
  logic                 qk_q, qk_d;
  logic                 cv_q, cv_d;
  logic                 cw_q, cw_d;
  logic                 cr_q, cr_d;
  logic                 lcs_n, lwe_n, lref_n;  // logical command pins

  // mirror swaps which ball carries each command pin
  assign lcs_n  = mir2_q ? loop_s[7] : loop_s[6];
  assign lwe_n  = mir2_q ? loop_s[6] : loop_s[7];
  assign lref_n = mir2_q ? loop_s[8] : loop_s[9];

  always_comb
  begin
    dq_d  = dq_q;
    oe_n_d = 1'b1;
    inv_d = '0;
    cv_d  = 1'b0;
    cw_d  = 1'b0;
    cr_d  = 1'b0;
    // read clock follows main clock, phase not guaranteed
    qk_d  = s2_q[SW-2];
    if (st_q == ddt_pkg::DDT_LOOP)
    begin
      oe_n_d = 1'b0;
      // read data left from normal mode is cleared off unmapped lines
      dq_d   = dq_q & place('1);
      // unmapped positions stay low, inversion flags low
      if (ck_rise)
        dq_d = place(rise_q[`DDT_LAT-1]);
      else if (ck_fall)
        dq_d = place(~fall_q[`DDT_LAT-1]);
    end
    else
    begin
      // drive only while read data is present
      dq_d   = rd_data;
      oe_n_d = ~rd_valid;
      inv_d  = rd_inv;
      // refresh and all commands decoded only in the normal state
      if (st_q == ddt_pkg::DDT_NORM && ck_rise && (!lcs_n || !lref_n))
      begin
        cv_d = 1'b1;
        cw_d = !lwe_n;
        cr_d = !lref_n;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dq_q   <= '0;
      oe_n_q <= 1'b1;
      inv_q  <= '0;
      qk_q   <= 1'b0;
      cv_q   <= 1'b0;
      cw_q   <= 1'b0;
      cr_q   <= 1'b0;
    end
    else
    begin
      dq_q   <= dq_d;
      oe_n_q <= oe_n_d;
      inv_q  <= inv_d;
      qk_q   <= qk_d;
      cv_q   <= cv_d;
      cw_q   <= cw_d;
      cr_q   <= cr_d;
    end
  end

  // outputs
  assign dq_out               = dq_q;
  assign dq_oe_n              = oe_n_q;
  assign inversion_flag_lines = inv_q;
  assign read_data_clocks     = qk_q;
  assign cmd_valid            = cv_q;
  assign cmd_we               = cw_q;
  assign cmd_ref              = cr_q;
  assign self_refresh         = (st_q == ddt_pkg::DDT_LOOP);
  assign pll_bypass           = (st_q == ddt_pkg::DDT_LOOP);
  assign pll_run              = pll_en_q & ~pll_bypass;
  assign inv_enable           = inversion_flag_lines_q & ~pll_bypass;
  assign beat_mask            = adm_q ? beat_sel(dmp_q) : 4'hf;

  // checks
  sequence s_in_loop;
    (st_q == ddt_pkg::DDT_LOOP) [*2];
  endsequence

  property p_lb_drive;
    @(posedge clock) disable iff (sys_rst) s_in_loop |-> !dq_oe_n;
  endproperty
  a_lb_drive: assert property (p_lb_drive) else $error("loop outputs not driven");

  property p_rise_out;
    @(posedge clock) disable iff (sys_rst)
      (ck_rise && st_q == ddt_pkg::DDT_LOOP) |=> dq_out == place($past(rise_q[4]));
  endproperty
  a_rise_out: assert property (p_rise_out) else $error("rise sample wrong");

  property p_fall_out;
    @(posedge clock) disable iff (sys_rst)
      (ck_fall && st_q == ddt_pkg::DDT_LOOP) |=> dq_out == place(~$past(fall_q[4]));
  endproperty
  a_fall_out: assert property (p_fall_out) else $error("fall sample not inverted");

  property p_no_inv;
    @(posedge clock) disable iff (sys_rst)
      s_in_loop |-> inversion_flag_lines == '0 && !inv_enable;
  endproperty
  a_no_inv: assert property (p_no_inv) else $error("inversion in loopback");

  property p_unmapped;
    @(posedge clock) disable iff (sys_rst) s_in_loop |-> (dq_out & ~place('1)) == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped line driven");

  property p_no_cmd;
    @(posedge clock) disable iff (sys_rst)
      (st_q != ddt_pkg::DDT_NORM) |=> !cmd_valid;
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("command in loopback");

  property p_bypass;
    @(posedge clock) disable iff (sys_rst)
      s_in_loop |-> pll_bypass && self_refresh && !pll_run;
  endproperty
  a_bypass: assert property (p_bypass) else $error("loop not bypassed");

  property p_pll_keep;
    @(posedge clock) disable iff (sys_rst)
      (st_q != ddt_pkg::DDT_NORM) |=> pll_en_q == $past(pll_en_q);
  endproperty
  a_pll_keep: assert property (p_pll_keep) else $error("loop setting changed");

  property p_mask;
    @(posedge clock) disable iff (sys_rst)
      (adm_q && dmp_q == 2'h2) |-> beat_mask == 4'h2;
  endproperty
  a_mask: assert property (p_mask) else $error("wrong masked beat");

  property p_pll_rst;
    @(posedge clock) sys_rst |=> !pll_en_q;
  endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("loop not off after reset");

endmodule

// ===== verification/ddt_ctrl_model.sv
// controller-side model: main clock, loopback select, command balls
`timescale 1ns/1ps
module ddt_ctrl_model (
  // link pins toward the device
  output logic       main_clk_pin,
  output logic       loopback_select_n,
  output logic [1:0] write_data_clocks,
  output logic       cs_n,
  output logic       we_n,
  output logic       ref_n,
  output logic [6:0] address_inputs
);
  logic [11:0] balls;  // ball values in loop-map order, all high = idle

  // free-running main clock, phase unrelated to the system clock
  initial
  begin
    main_clk_pin = 1'b0;
    loopback_select_n = 1'b1;
    balls = 12'hfff;
    #1.3;
    forever #62.5 main_clk_pin = ~main_clk_pin;
  end

  // fan the ball vector out to the named pins
  assign address_inputs = {balls[0], balls[2], balls[4], balls[5], balls[8], balls[11], balls[10]};
  assign write_data_clocks = {balls[3], balls[1]};
  assign cs_n = balls[6];
  assign we_n = balls[7];
  assign ref_n = balls[9];

  // wait for n main-clock rises
  task automatic rises(input int n);
    repeat (n) @(posedge main_clk_pin);
  endtask

  // change balls mid half-period, clear of both edges
  task automatic put(input logic [11:0] v);
    #31 balls = v;
  endtask

  // balls held across exactly one main-clock rise
  task automatic pulse(input logic [11:0] v);
    @(negedge main_clk_pin);
    put(v);
    @(negedge main_clk_pin);
    put(12'hfff);
  endtask

  // idle guard, select low, settle before patterns
  task automatic enter_loop();
    rises(16);
    loopback_select_n = 1'b0;
    rises(16);
  endtask

  // idle balls, then release the select
  task automatic exit_loop();
    @(negedge main_clk_pin);
    put(12'hfff);
    loopback_select_n = 1'b1;
  endtask
endmodule

// ===== verification/test_deskew_loopback_training.sv
// testbench: loopback training, mode bits and command decode
`timescale 1ns/1ps
`include "ddt_consts.svh"
module test_deskew_loopback_training;
  // device side
  logic        clock, sys_rst, mirror_select, cfg_wr, cfg_pll, cfg_adm, cfg_inversion_flag_lines;
  logic [1:0]  cfg_dmp, write_data_clocks;
  logic [35:0] rd_data, dq_out;
  logic [3:0]  rd_inv, inversion_flag_lines, beat_mask;
  logic        rd_valid, dq_oe_n, read_data_clocks, cmd_valid, cmd_we, cmd_ref;
  logic        self_refresh, pll_bypass, pll_run, inv_enable;
  // link pins
  logic        main_clk_pin, loopback_select_n, cs_n, we_n, ref_n;
  logic [6:0]  address_inputs;
  // bench state
  int          failures, n_checks, n_cmd, n0;
  logic        rise;
  logic [1:0]  cmd_last;                 // {write, refresh} of the last command
  localparam int MRD_CYC = 4;            // mode register delay, plain default
  localparam int POS [12] = '{0, 1, 3, 14, 18, 19, 20, 21, 22, 25, 24, 26};
  localparam logic [1:0] AUTO_MASK_PATTERN [4] = '{`DDT_DMP_B0, `DDT_DMP_B1, `DDT_DMP_B2, `DDT_DMP_B3};

  ddt_ctrl_model i_ddt_ctrl_model (.main_clk_pin, .loopback_select_n, .write_data_clocks,
    .cs_n, .we_n, .ref_n, .address_inputs);

  ddt_loopback #(.WIDE(1'b1)) i_ddt_loopback (.clock, .sys_rst, .main_clk_pin,
    .loopback_select_n, .mirror_select, .write_data_clocks, .cs_n, .we_n, .ref_n,
    .address_inputs, .cfg_wr, .cfg_pll, .cfg_adm, .cfg_dmp, .cfg_inversion_flag_lines, .rd_data, .rd_inv,
    .rd_valid, .dq_out, .dq_oe_n, .inversion_flag_lines, .read_data_clocks, .cmd_valid,
    .cmd_we, .cmd_ref, .self_refresh, .pll_bypass, .pll_run, .inv_enable, .beat_mask);

  // 200 MHz system clock
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // count decoded command pulses, sampled away from the launching edge
  always @(negedge clock)
    if (cmd_valid === 1'b1)
    begin
      n_cmd++;
      cmd_last = {cmd_we, cmd_ref};
    end

  // ball vector placed on its data output positions
  function automatic logic [35:0] map(input logic [11:0] v);
    logic [35:0] m;
    m = '0;
    for (int i = 0; i < 12; i++)
      m[POS[i]] = v[i];
    return m;
  endfunction

  // loop pattern for half-period k
  function automatic logic [11:0] pat(input int k);
    return 12'(k * 12'h2c9) ^ 12'ha5c;
  endfunction

  // single compare for all results
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // core-side mode inputs from arguments
  task automatic drive_cfg(input logic p, input logic a, input logic [1:0] m, input logic d,
                           input logic w);
    {cfg_pll, cfg_adm, cfg_dmp, cfg_inversion_flag_lines, cfg_wr} = {p, a, m, d, w};
  endtask

  // core-side read data from arguments
  task automatic drive_rd(input logic [35:0] d, input logic [3:0] v, input logic ok);
    {rd_data, rd_inv, rd_valid} = {d, v, ok};
  endtask

  // one mode register write, then the quiet delay
  task automatic cfg(input logic p, input logic a, input logic [1:0] m, input logic d);
    @(posedge clock);
    #1 drive_cfg(p, a, m, d, 1'b1);
    @(posedge clock);
    #1 drive_cfg(p, a, m, d, 1'b0);
    repeat (MRD_CYC) @(posedge clock);
    #1;
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog well past the expected run
  initial
  begin
    #200_000;
    failures++;
    finish_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    mirror_select = 1'b0;
    drive_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    drive_rd(36'h0, 4'h0, 1'b0);
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    @(posedge clock);
    #1 check(36'(dq_oe_n), 36'h1);
    check(36'({pll_run, inv_enable, self_refresh, beat_mask}), 36'hf);
    // every auto-mask code selects one beat
    for (int i = 0; i < 4; i++)
    begin
      cfg(1'b1, 1'b1, AUTO_MASK_PATTERN[i], 1'b1);
      check(36'(beat_mask), 36'(4'h1 << i));
    end
    check(36'({pll_run, inv_enable}), 36'h3);
    // normal read drives the data pins
    drive_rd(36'h9_8765_4321, 4'h5, 1'b1);
    @(posedge clock);
    #1 check(dq_out, 36'h9_8765_4321);
    check(36'({dq_oe_n, inversion_flag_lines}), 36'h5);
    drive_rd(36'h0, 4'h0, 1'b0);
    // commands: plain select, mirrored write, mirrored refresh
    n0 = n_cmd;
    cmd_last = 2'h3;
    i_ddt_ctrl_model.pulse(12'hfbf);
    check(36'(cmd_last), 36'h0);
    @(posedge clock);
    #1 mirror_select = 1'b1;
    i_ddt_ctrl_model.pulse(12'hfbf);
    i_ddt_ctrl_model.pulse(12'hf3f);
    check(36'(cmd_last), 36'h2);
    i_ddt_ctrl_model.pulse(12'heff);
    i_ddt_ctrl_model.rises(2);
    check(36'(cmd_last), 36'h1);
    check(36'(n_cmd - n0), 36'h3);
    // loopback with mirror set, map stays per ball
    i_ddt_ctrl_model.enter_loop();
    check(36'({self_refresh, pll_bypass, pll_run, inv_enable, dq_oe_n}), 36'h18);
    cfg(1'b0, 1'b0, 2'h0, 1'b0);
    n0 = n_cmd;
    for (int k = 0; k < 40; k++)
    begin
      @(main_clk_pin);
      rise = main_clk_pin;
      i_ddt_ctrl_model.put(pat(k));
      if (k >= 11)
      begin
        check(dq_out & map(12'hfff), map(rise ? pat(k - 11) : ~pat(k - 11)));
        check(36'(inversion_flag_lines), 36'h0);
        check(36'(read_data_clocks), 36'(rise));
      end
    end
    check(36'(n_cmd - n0), 36'h0);
    // exit restores settings, guard refuses commands
    i_ddt_ctrl_model.exit_loop();
    i_ddt_ctrl_model.rises(1);
    check(36'({self_refresh, pll_bypass, pll_run, inv_enable, beat_mask}), 36'h38);
    check(36'(dq_oe_n), 36'h1);
    n0 = n_cmd;
    i_ddt_ctrl_model.pulse(12'hf7f);
    i_ddt_ctrl_model.rises(16);
    check(36'(n_cmd - n0), 36'h0);
    i_ddt_ctrl_model.pulse(12'hf7f);
    i_ddt_ctrl_model.rises(2);
    check(36'(n_cmd - n0), 36'h1);
    finish_test();
  end
endmodule
